// ===== common/grb_regs.svh
/*
 * Register offsets, field positions, reset values and timing constants
 * of the global register bank.
 * Assumes a 32-bit AXI4-Lite bus with one register per aligned word.
 */
// Operation
// - Low ID byte bits 5,4,3 flag RMII, MII and PHY presence; 7,6 reserved.
// - Low ID byte bits 2..0 hold the die revision count.
// - High ID byte bits 7..5 hold number of ports minus one.
// - High ID byte bit 4 flags line unit, bit 3 framer; bit 2 reserved.
// - High ID byte bit 1 flags encapsulation, bit 0 inverse multiplexing.
// - Reference clock off bit stops the output and holds it low.
// - Interrupt pin drives low when active; idle is high-Z or driven high.
// - Global reset bit resets data path and all registers except itself.
// - BERT connect bit attaches BERT to serial transmit and receive ports.
// - BERT overrides the serial connection; clearing it restores the prior one.
// - In hardware mode the BERT is unavailable.
// - Serial receive clock activity latches bit 4; cleared on read.
// - Serial transmit clock activity latches bit 0; cleared on read.
// - Reference clock toggling latches memory activity bit 1; read clears.
// - System clock toggling latches memory activity bit 0; read clears.
// - Enable bit 4 lets transmit status raise the interrupt.
// - Enable bit 0 lets receive status raise the interrupt.
// - Status bit 4 is set by an enabled serial transmit event.
// - Status bit 0 is set by an enabled serial receive event.
`ifndef GRB_REGS_SVH
`define GRB_REGS_SVH

// ****************************************************************
// Register word indices (byte address bits 7..2).
// ****************************************************************
`define GRB_IDX_CAP_LOW 6'h00
`define GRB_IDX_CAP_HIGH 6'h01
`define GRB_IDX_BERT_SEL 6'h03
`define GRB_IDX_SER_ACT 6'h04
`define GRB_IDX_MEM_ACT 6'h05
`define GRB_IDX_IRQ_EN 6'h06
`define GRB_IDX_IRQ_STAT 6'h07
`define GRB_IDX_GCTRL 6'h12
`define GRB_IDX_STRAP 6'h13

// ****************************************************************
// Field positions.
// ****************************************************************
`define GRB_CAPL_RMII 5
`define GRB_CAPL_MII 4
`define GRB_CAPL_PHY 3
`define GRB_CAPL_REV_HI 2
`define GRB_CAPL_REV_LO 0
`define GRB_CAPH_PORTS_HI 7
`define GRB_CAPH_PORTS_LO 5
`define GRB_CAPH_LIU 4
`define GRB_CAPH_FRAMER 3
`define GRB_CAPH_ENCAP 1
`define GRB_CAPH_IMUX 0
`define GRB_GC_REFOFF 2
`define GRB_GC_IRQMODE 1
`define GRB_GC_RESET 0
`define GRB_BERT_ATTACH 0
`define GRB_ACT_SER_RX 4
`define GRB_ACT_SER_TX 0
`define GRB_ACT_REF 1
`define GRB_ACT_SYS 0
`define GRB_IRQ_TX 4
`define GRB_IRQ_RX 0

// ****************************************************************
// Reset values and bus answers.
// ****************************************************************
`define GRB_RST_BYTE 8'h00
`define GRB_RESP_OKAY 2'h0
`define GRB_RESP_SLVERR 2'h2

// ****************************************************************
// Timing.
// ****************************************************************
`define GRB_CLK_PERIOD_NS 100
`define GRB_RESET_MIN_NS 100

`endif

// ===== common/grb_pkg.sv
/*
 * Types of the global register bank.
 * Assumes nothing of its surroundings.
 */
package grb_pkg;

  typedef enum logic [1:0] {
    GRB_W_IDLE = 2'b00,
    GRB_W_RESP = 2'b01
  } grb_wr_state_type;

  typedef logic [7:0] grb_byte_type;

endpackage : grb_pkg

// ===== design/grb_global_regs.sv
/*
 * Global register bank: identification, global control, BERT connect,
 * clock activity latches and serial interrupt enable and status.
 * Assumes an AXI4-Lite master on aclk and raw clocks from pins.
 */
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps
`include "grb_regs.svh"

module grb_global_regs #(
  parameter logic [2:0] DIE_REVISION = 3'h0,
  parameter logic [2:0] PORTS_MINUS_ONE = 3'h0,
  parameter logic RMII_PRESENT = 1'b1,
  parameter logic MII_PRESENT = 1'b1,
  parameter logic PHY_PRESENT = 1'b0,
  parameter logic LIU_PRESENT = 1'b0,
  parameter logic FRAMER_PRESENT = 1'b0,
  parameter logic ENCAP_PRESENT = 1'b1,
  parameter logic IMUX_PRESENT = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic hardware_mode,
  input wire logic serial_rx_clock,
  input wire logic serial_tx_clock,
  input wire logic ref_clock_in,
  input wire logic system_clock_input,
  input wire logic ref_clock_gen,
  input wire logic serial_tx_irq_event,
  input wire logic serial_rx_irq_event,
  output logic reference_clock_output,
  output logic irq_pin_out,
  output logic irq_pin_oe,
  output logic bert_attach_serial,
  output logic datapath_reset
);

  // ****************************************************************
  // Input synchronisers and activity edge detection.
  // ****************************************************************
  logic [5:0] pin_meta_q;
  logic [5:0] pin_sync_q;
  logic [3:0] clk_prev_q;
  logic [5:0] pin_raw;
  logic [3:0] clk_edge;
  logic hw_mode;

  assign pin_raw = {hardware_mode, ref_clock_gen, system_clock_input,
                    ref_clock_in, serial_tx_clock, serial_rx_clock};
  assign hw_mode = pin_sync_q[5];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_q <= 6'h00;
      pin_sync_q <= 6'h00;
      clk_prev_q <= 4'h0;
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
      clk_prev_q <= pin_sync_q[3:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_edge
      assign clk_edge[gi] = pin_sync_q[gi] ^ clk_prev_q[gi];
    end
  endgenerate

  // ****************************************************************
  // AXI4-Lite write channel.
  // ****************************************************************
  grb_pkg::grb_wr_state_type wr_state_q;
  logic aw_have_q;
  logic w_have_q;
  logic [5:0] aw_idx_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;
  logic wr_hit;
  logic wr_lane0;

  assign wr_fire = (wr_state_q == grb_pkg::GRB_W_IDLE) && aw_have_q &&
                   w_have_q;
  assign wr_lane0 = w_strb_q[0];
  always_comb begin
    case (aw_idx_q)
      `GRB_IDX_CAP_LOW, `GRB_IDX_CAP_HIGH, `GRB_IDX_BERT_SEL,
      `GRB_IDX_SER_ACT, `GRB_IDX_MEM_ACT, `GRB_IDX_IRQ_EN,
      `GRB_IDX_IRQ_STAT, `GRB_IDX_GCTRL, `GRB_IDX_STRAP: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= grb_pkg::GRB_W_IDLE;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_idx_q <= 6'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `GRB_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      case (wr_state_q)
        grb_pkg::GRB_W_IDLE: begin
          if (wr_fire) begin
            wr_state_q <= grb_pkg::GRB_W_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `GRB_RESP_OKAY : `GRB_RESP_SLVERR;
          end
        end
        grb_pkg::GRB_W_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            wr_state_q <= grb_pkg::GRB_W_IDLE;
          end
        end
        default: wr_state_q <= grb_pkg::GRB_W_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Register write strobes.
  // ****************************************************************
  logic wr_gctrl;
  logic wr_bert;
  logic wr_irq_en;

  assign wr_gctrl = wr_fire && wr_lane0 && aw_idx_q == `GRB_IDX_GCTRL;
  assign wr_bert = wr_fire && wr_lane0 && aw_idx_q == `GRB_IDX_BERT_SEL;
  assign wr_irq_en = wr_fire && wr_lane0 && aw_idx_q == `GRB_IDX_IRQ_EN;

  // ****************************************************************
  // Global control register.
  // ****************************************************************
  logic gc_reset_q;
  logic gc_refoff_q;
  logic gc_irqmode_q;
  logic soft_rst;
  logic bank_rst;

  assign soft_rst = gc_reset_q;
  assign bank_rst = !aresetn || soft_rst;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gc_reset_q <= 1'b0;
    end else if (wr_gctrl) begin
      gc_reset_q <= w_data_q[`GRB_GC_RESET];
    end
  end

  // The soft reset spares its own bit, so software can release it.
  always_ff @(posedge aclk) begin
    if (bank_rst) begin
      gc_refoff_q <= 1'b0;
    end else if (wr_gctrl) begin
      gc_refoff_q <= w_data_q[`GRB_GC_REFOFF];
    end
  end

  always_ff @(posedge aclk) begin
    if (bank_rst) begin
      gc_irqmode_q <= 1'b0;
    end else if (wr_gctrl) begin
      gc_irqmode_q <= w_data_q[`GRB_GC_IRQMODE];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      datapath_reset <= 1'b0;
    end else begin
      datapath_reset <= soft_rst;
    end
  end

  // ****************************************************************
  // BERT connect and interrupt enable registers.
  // ****************************************************************
  logic bert_sel_q;
  logic [1:0] irq_en_q;

  always_ff @(posedge aclk) begin
    if (bank_rst) begin
      bert_sel_q <= 1'b0;
    end else if (wr_bert) begin
      bert_sel_q <= w_data_q[`GRB_BERT_ATTACH];
    end
  end

  always_ff @(posedge aclk) begin
    if (bank_rst) begin
      irq_en_q <= 2'h0;
    end else if (wr_irq_en) begin
      irq_en_q <= {w_data_q[`GRB_IRQ_TX], w_data_q[`GRB_IRQ_RX]};
    end
  end

  always_ff @(posedge aclk) begin
    if (bank_rst) begin
      bert_attach_serial <= 1'b0;
    end else begin
      // Clearing restores the prior connection, which is never altered.
      bert_attach_serial <= bert_sel_q && !hw_mode;
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel and clear-on-read latches.
  // ****************************************************************
  logic [3:0] act_q;
  logic [1:0] irq_stat_q;
  logic rd_take;
  logic rd_ser;
  logic rd_mem;
  logic [7:0] rd_byte;
  logic rd_ok;

  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rd_ser = rd_take && s_axi_araddr[7:2] == `GRB_IDX_SER_ACT;
  assign rd_mem = rd_take && s_axi_araddr[7:2] == `GRB_IDX_MEM_ACT;

  always_comb begin
    rd_byte = `GRB_RST_BYTE;
    rd_ok = 1'b1;
    case (s_axi_araddr[7:2])
      `GRB_IDX_CAP_LOW: begin
        rd_byte[`GRB_CAPL_RMII] = RMII_PRESENT;
        rd_byte[`GRB_CAPL_MII] = MII_PRESENT;
        rd_byte[`GRB_CAPL_PHY] = PHY_PRESENT;
        rd_byte[`GRB_CAPL_REV_HI:`GRB_CAPL_REV_LO] = DIE_REVISION;
      end
      `GRB_IDX_CAP_HIGH: begin
        rd_byte[`GRB_CAPH_PORTS_HI:`GRB_CAPH_PORTS_LO] =
          PORTS_MINUS_ONE;
        rd_byte[`GRB_CAPH_LIU] = LIU_PRESENT;
        rd_byte[`GRB_CAPH_FRAMER] = FRAMER_PRESENT;
        rd_byte[`GRB_CAPH_ENCAP] = ENCAP_PRESENT;
        rd_byte[`GRB_CAPH_IMUX] = IMUX_PRESENT;
      end
      `GRB_IDX_BERT_SEL: rd_byte[`GRB_BERT_ATTACH] = bert_sel_q;
      `GRB_IDX_SER_ACT: begin
        rd_byte[`GRB_ACT_SER_RX] = act_q[0];
        rd_byte[`GRB_ACT_SER_TX] = act_q[1];
      end
      `GRB_IDX_MEM_ACT: begin
        rd_byte[`GRB_ACT_REF] = act_q[2];
        rd_byte[`GRB_ACT_SYS] = act_q[3];
      end
      `GRB_IDX_IRQ_EN: begin
        rd_byte[`GRB_IRQ_TX] = irq_en_q[1];
        rd_byte[`GRB_IRQ_RX] = irq_en_q[0];
      end
      `GRB_IDX_IRQ_STAT: begin
        rd_byte[`GRB_IRQ_TX] = irq_stat_q[1];
        rd_byte[`GRB_IRQ_RX] = irq_stat_q[0];
      end
      `GRB_IDX_GCTRL: begin
        rd_byte[`GRB_GC_REFOFF] = gc_refoff_q;
        rd_byte[`GRB_GC_IRQMODE] = gc_irqmode_q;
        rd_byte[`GRB_GC_RESET] = gc_reset_q;
      end
      `GRB_IDX_STRAP: rd_byte[0] = hw_mode;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `GRB_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_ok ? `GRB_RESP_OKAY : `GRB_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Set wins over the clearing read.
  always_ff @(posedge aclk) begin
    if (bank_rst) begin
      act_q <= 4'h0;
    end else begin
      act_q[0] <= clk_edge[0] || (act_q[0] && !rd_ser);
      act_q[1] <= clk_edge[1] || (act_q[1] && !rd_ser);
      act_q[2] <= clk_edge[2] || (act_q[2] && !rd_mem);
      act_q[3] <= clk_edge[3] || (act_q[3] && !rd_mem);
    end
  end

  // ****************************************************************
  // Serial interrupt status and interrupt pin.
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (bank_rst) begin
      irq_stat_q <= 2'h0;
    end else begin
      irq_stat_q[1] <= serial_tx_irq_event && irq_en_q[1];
      irq_stat_q[0] <= serial_rx_irq_event && irq_en_q[0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_pin_out <= 1'b1;
      irq_pin_oe <= 1'b1;
    end else if (|(irq_stat_q & irq_en_q)) begin
      irq_pin_out <= 1'b0;
      irq_pin_oe <= 1'b1;
    end else begin
      irq_pin_out <= 1'b1;
      irq_pin_oe <= !gc_irqmode_q;
    end
  end

  // ****************************************************************
  // Reference clock output.
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reference_clock_output <= 1'b0;
    end else if (gc_refoff_q) begin
      reference_clock_output <= 1'b0;
    end else begin
      reference_clock_output <= pin_sync_q[4];
    end
  end

endmodule : grb_global_regs

// ===== test/grb_global_regs_sva.sv
/* Port checker of the global register bank.
   Assumes binding to grb_global_regs on aclk. */
`timescale 1ns/10ps
module grb_global_regs_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic hardware_mode,
  input wire logic serial_tx_irq_event,
  input wire logic serial_rx_irq_event,
  input wire logic irq_pin_out,
  input wire logic irq_pin_oe,
  input wire logic bert_attach_serial,
  input wire logic datapath_reset
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_irq_drive_low: assert property (!irq_pin_out |-> irq_pin_oe)
    else $error("interrupt low while undriven");
  a_irq_has_cause: assert property ($fell(irq_pin_out) |->
    $past(serial_tx_irq_event, 2) || $past(serial_rx_irq_event, 2))
    else $error("interrupt without event");
  a_hw_no_bert: assert property (hardware_mode [*4] |=>
    !bert_attach_serial)
    else $error("bert attached in hardware mode");
  a_soft_clears: assert property (datapath_reset |=>
    irq_pin_out && !bert_attach_serial)
    else $error("soft reset left state");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  a_write_refuse: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_read_upper: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
endmodule : grb_global_regs_sva

bind grb_global_regs grb_global_regs_sva chk (.*);

// ===== test/grb_host_model.sv
/* Host processor model: AXI4-Lite master tasks.
   Assumes the bank shares aclk and answers every request. */
`timescale 1ns/10ps
module grb_host_model (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr} = 16'h0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] rs);
    logic aw_busy;
    logic w_busy;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    aw_busy = 1'b1;
    w_busy = 1'b1;
    while (aw_busy || w_busy) begin
      @(posedge aclk);
      if (aw_busy && s_axi_awready === 1'b1) begin
        aw_busy = 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (w_busy && s_axi_wready === 1'b1) begin
        w_busy = 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : grb_host_model

// ===== test/tb_global_register_bank.sv
/* Self-checking bench of the global register bank.
   Assumes the host model and the bound port checker. */
`timescale 1ns/10ps
`include "grb_regs.svh"
module tb_global_register_bank;
  localparam logic [2:0] REV = 3'h5;
  localparam logic [2:0] PORTS = 3'h2;
  localparam logic [2:0] CAPL = 3'h3;
  localparam logic [3:0] CAPH = 4'h9;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic hardware_mode = 1'b0;
  logic [3:0] act_clk = 4'h0;
  logic ref_clock_gen = 1'b0;
  logic serial_tx_irq_event = 1'b0;
  logic serial_rx_irq_event = 1'b0;
  wire logic serial_rx_clock = act_clk[0];
  wire logic serial_tx_clock = act_clk[1];
  wire logic ref_clock_in = act_clk[2];
  wire logic system_clock_input = act_clk[3];
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic reference_clock_output, irq_pin_out, irq_pin_oe;
  logic bert_attach_serial, datapath_reset;
  int error_cnt = 0;
  int checks_done = 0;
  int mdl[int];

  always #50 aclk = ~aclk;
  always @(posedge aclk) ref_clock_gen <= ~ref_clock_gen;

  grb_global_regs #(.DIE_REVISION(REV), .PORTS_MINUS_ONE(PORTS),
    .RMII_PRESENT(CAPL[2]), .MII_PRESENT(CAPL[1]), .PHY_PRESENT(CAPL[0]),
    .LIU_PRESENT(CAPH[3]), .FRAMER_PRESENT(CAPH[2]),
    .ENCAP_PRESENT(CAPH[1]), .IMUX_PRESENT(CAPH[0])) uut (.*);
  grb_host_model h (.*);

  // ****************************************************************
  // Compare, bus and closing tasks.
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic pin(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : pin

  function automatic logic [31:0] msk(input logic [7:0] a);
    case (a)
      8'h0C: msk = 32'h1;
      8'h18: msk = 32'h11;
      8'h48: msk = 32'h7;
      default: msk = 32'h0;
    endcase
  endfunction : msk

  function automatic logic [31:0] rsp(input logic [7:0] a);
    rsp = (a inside {8'h00, 8'h04, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
      8'h48, 8'h4C}) ? `GRB_RESP_OKAY : `GRB_RESP_SLVERR;
  endfunction : rsp

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] rs;
    h.wr(a, d, rs);
    chk({30'h0, rs}, rsp(a));
    if (mdl.exists(a)) mdl[a] = d & msk(a);
    if (a == 8'h48 && d[0]) begin
      mdl[8'h0C] = 0;
      mdl[8'h18] = 0;
      mdl[8'h48] = 1;
    end
  endtask : w

  task automatic r(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] rs;
    h.rd(a, d, rs);
    chk({30'h0, rs}, rsp(a));
    chk(d, e);
  endtask : r

  task automatic watch(output int n);
    logic lv;
    n = 0;
    lv = reference_clock_output;
    repeat (8) begin
      @(posedge aclk);
      if (reference_clock_output !== lv) n++;
      lv = reference_clock_output;
    end
  endtask : watch

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // The whole sequence needs about 310 cycles.
  initial begin
    repeat (5000) @(posedge aclk);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    int n;
    logic [7:0] a;
    logic [31:0] d;
    logic [1:0] rs;
    logic [31:0] x;
    void'($urandom(32'hA140C431));
    mdl[8'h0C] = 0;
    mdl[8'h18] = 0;
    mdl[8'h48] = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    r(8'h00, {26'h0, CAPL, REV});
    w(8'h04, 32'hFFFF_FFFF);
    r(8'h04, {24'h0, PORTS, CAPH[3:2], 1'b0, CAPH[1:0]});
    r(8'h1C, 32'h0);
    for (int i = 0; i < 9; i++) begin
      a = (i % 3 == 0) ? 8'h0C : (i % 3 == 1) ? 8'h18 : 8'h48;
      w(a, $urandom & 32'hFFFF_FFFE);
      r(a, 32'(mdl[a]));
    end
    w(8'h08, 32'h0000_00FF);
    r(8'h08, 32'h0);
    r(8'h50, 32'h0);
    w(8'h48, 32'h0);
    w(8'h0C, 32'h1);
    repeat (2) @(posedge aclk);
    pin(bert_attach_serial, 1'b1);
    hardware_mode <= 1'b1;
    repeat (5) @(posedge aclk);
    pin(bert_attach_serial, 1'b0);
    r(8'h4C, 32'h1);
    hardware_mode <= 1'b0;
    repeat (5) @(posedge aclk);
    pin(bert_attach_serial, 1'b1);
    w(8'h0C, 32'h0);
    repeat (2) @(posedge aclk);
    pin(bert_attach_serial, 1'b0);
    w(8'h48, 32'h4);
    repeat (4) @(posedge aclk);
    watch(n);
    chk(32'(n), 32'h0);
    pin(reference_clock_output, 1'b0);
    w(8'h48, 32'h2);
    repeat (4) @(posedge aclk);
    watch(n);
    pin(n != 0, 1'b1);
    pin(irq_pin_oe, 1'b0);
    w(8'h48, 32'h0);
    repeat (2) @(posedge aclk);
    pin(irq_pin_oe, 1'b1);
    pin(irq_pin_out, 1'b1);
    for (int k = 0; k < 2; k++) begin
      w(8'h18, k ? 32'h10 : 32'h01);
      serial_tx_irq_event <= (k == 1);
      serial_rx_irq_event <= (k == 0);
      repeat (3) @(posedge aclk);
      pin(irq_pin_out, 1'b0);
      r(8'h1C, k ? 32'h10 : 32'h01);
      w(8'h18, 32'h0);
      repeat (3) @(posedge aclk);
      pin(irq_pin_out, 1'b1);
      r(8'h1C, 32'h0);
      {serial_tx_irq_event, serial_rx_irq_event} <= 2'b00;
    end
    for (int j = 0; j < 4; j++) begin
      a = (j < 2) ? 8'h10 : 8'h14;
      x = (j == 0) ? 32'h10 : (j == 2) ? 32'h2 : 32'h1;
      h.rd(a, d, rs);
      act_clk[j] <= ~act_clk[j];
      repeat (4) @(posedge aclk);
      r(a, x);
      r(a, 32'h0);
      // The next edge reaches the latch at the clearing read's handshake.
      act_clk[j] <= ~act_clk[j];
      @(posedge aclk);
      r(a, 32'h0);
      r(a, x);
    end
    w(8'h0C, 32'h1);
    w(8'h18, 32'h11);
    w(8'h48, 32'h7);
    repeat (2) @(posedge aclk); // Wait two cycles with the reset bit set.
    pin(datapath_reset, 1'b1);
    r(8'h48, 32'h1);
    w(8'h48, 32'h0);
    repeat (2) @(posedge aclk);
    pin(datapath_reset, 1'b0);
    pin(bert_attach_serial, 1'b0);
    r(8'h0C, 32'h0);
    r(8'h18, 32'h0);
    tally_and_finish();
  end
endmodule : tb_global_register_bank
